/* File: design/eeprom_pkg.sv */
// Shared constants and types for the two-wire EEPROM device and its bus master
// Behaviour
// - No acknowledge at all while programming
// - Stop after write starts programming
// - Master polls with write control byte
// - Poll acknowledged only once programming ends
// - Read bit one starts a read
// - Pointer holds last location plus one
// - Ack read control, send byte MSB first
// - Master nacks last byte; device releases
// - Random read: address then repeated Start
// - Repeated Start aborts write, keeps address
// - Master resends control byte with read
// - Master ack requests next sequential byte
// - Pointer increments after every byte access
// - Clock and data inputs are spike filtered
// - Control byte: code, ignored, block, rw
// - Word address gives eight low bits
package eeprom_pkg;
   localparam int CLK_FREQ_HZ = 20_000_000;
   localparam int SCL_FREQ_HZ = 100_000;
   localparam int QUARTER_CYCLES = CLK_FREQ_HZ / (SCL_FREQ_HZ * 4);
   localparam int FILTER_TIME_NS = 200;
   localparam int FILTER_CYCLES = (FILTER_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
   localparam int WRITE_TIME_US = 5000;
   localparam int WRITE_CYCLES = WRITE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;
   localparam logic [3:0] CTRL_CODE = 4'ha;
   localparam int CODE_MSB = 7;
   localparam int CODE_LSB = 4;
   localparam int BLOCK_MSB = 2;
   localparam int BLOCK_LSB = 1;
   localparam int RW_BIT = 0;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] ACK_DONE = 4'h9;
   localparam logic [7:0] LEN_DEFAULT = 8'h01;

   typedef enum logic [1:0] {OP_WRITE, OP_CURRENT_READ, OP_RANDOM_READ, OP_ACK_POLL} op_t;
endpackage : eeprom_pkg

/* File: design/two_wire_if.sv */
// Open-drain two-wire bus joining the master and the EEPROM device
`timescale 1ns/1ps
interface two_wire_if;
   logic scl_m_o;
   logic scl_m_oe;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_s_o;
   logic sda_s_oe;
   logic scl;
   logic sda;

   // Wired-AND with pull-up: a line is low while any driver pulls it low
   assign scl = !(scl_m_oe && !scl_m_o);
   assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

   modport master (output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
   modport device (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : two_wire_if

/* File: design/eeprom_device.sv */
// EEPROM device end: filtered bus slave, address pointer, array and write timer
`timescale 1ns/1ps
module eeprom_device #(
   parameter int WRITE_CYCLES_P = eeprom_pkg::WRITE_CYCLES,
   parameter int FILTER_LEN = eeprom_pkg::FILTER_CYCLES,
   parameter int ADDR_W = eeprom_pkg::ADDR_W
) (
   input wire logic clk,
   input wire logic rst,
   two_wire_if.device bus,
   output logic write_busy
);
   import eeprom_pkg::*;

   localparam int CNT_W = $clog2(WRITE_CYCLES_P + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WRITE_CYCLES_P - 1);
   localparam int DEPTH = 1 << ADDR_W;

   typedef enum logic [2:0] {D_IDLE, D_CTRL, D_ADDR, D_WDATA, D_READ} dev_state_t;

   dev_state_t state_reg;
   logic [FILTER_LEN-1:0] scl_hist_reg;
   logic [FILTER_LEN-1:0] sda_hist_reg;
   logic scl_f_reg;
   logic sda_f_reg;
   logic scl_prev_reg;
   logic sda_prev_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] rx_reg;
   logic [7:0] tx_reg;
   logic rw_reg;
   logic master_ack_reg;
   logic sda_oe_reg;
   logic [1:0] block_reg;
   logic [ADDR_W-1:0] ptr_reg;
   logic [ADDR_W-1:0] pend_addr_reg;
   logic [7:0] pend_data_reg;
   logic pend_valid_reg;
   logic busy_reg;
   logic [CNT_W-1:0] busy_cnt_reg;
   logic [7:0] mem [DEPTH];

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic byte_fall;
   logic ack_fall;
   logic ctrl_match;
   logic addr_load;
   logic data_take;
   logic read_load;
   logic prog_done;
   logic [7:0] rd_byte;

   // Spike filter: a line changes only after FILTER_LEN equal samples
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_hist_reg <= '1;
         sda_hist_reg <= '1;
         scl_f_reg <= 1'b1;
         sda_f_reg <= 1'b1;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_hist_reg <= {scl_hist_reg[FILTER_LEN-2:0], bus.scl};
         sda_hist_reg <= {sda_hist_reg[FILTER_LEN-2:0], bus.sda};
         if (&scl_hist_reg) begin
            scl_f_reg <= 1'b1;
         end else if (~|scl_hist_reg) begin
            scl_f_reg <= 1'b0;
         end
         if (&sda_hist_reg) begin
            sda_f_reg <= 1'b1;
         end else if (~|sda_hist_reg) begin
            sda_f_reg <= 1'b0;
         end
         scl_prev_reg <= scl_f_reg;
         sda_prev_reg <= sda_f_reg;
      end
   end

   // Bus events seen on the filtered lines
   assign scl_rise = scl_f_reg && !scl_prev_reg;
   assign scl_fall = !scl_f_reg && scl_prev_reg;
   assign start_cond = scl_f_reg && scl_prev_reg && sda_prev_reg && !sda_f_reg;
   assign stop_cond = scl_f_reg && scl_prev_reg && !sda_prev_reg && sda_f_reg;
   assign byte_fall = scl_fall && (bit_cnt_reg == ACK_SLOT) && (state_reg != D_IDLE);
   assign ack_fall = scl_fall && (bit_cnt_reg == ACK_DONE) && (state_reg != D_IDLE);
   assign ctrl_match = (rx_reg[CODE_MSB:CODE_LSB] == CTRL_CODE) && !busy_reg;
   assign addr_load = byte_fall && (state_reg == D_ADDR);
   assign data_take = byte_fall && (state_reg == D_WDATA);
   assign read_load = ack_fall && !start_cond && !stop_cond
                      && (((state_reg == D_CTRL) && rw_reg) || ((state_reg == D_READ) && master_ack_reg));
   assign prog_done = busy_reg && (busy_cnt_reg == CNT_LAST);
   assign rd_byte = mem[ptr_reg];

   // Byte framing, acknowledge and transmit shifting
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= D_IDLE;
         bit_cnt_reg <= 4'h0;
         rx_reg <= 8'h00;
         tx_reg <= 8'h00;
         rw_reg <= 1'b0;
         master_ack_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         block_reg <= 2'h0;
      end else if (start_cond) begin
         state_reg <= D_CTRL;
         bit_cnt_reg <= 4'h0;
         sda_oe_reg <= 1'b0;
      end else if (stop_cond) begin
         state_reg <= D_IDLE;
         bit_cnt_reg <= 4'h0;
         sda_oe_reg <= 1'b0;
      end else if (state_reg != D_IDLE) begin
         if (scl_rise) begin
            if (bit_cnt_reg < ACK_SLOT) begin
               rx_reg <= {rx_reg[6:0], sda_f_reg};
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (bit_cnt_reg == ACK_SLOT) begin
               master_ack_reg <= !sda_f_reg;
               bit_cnt_reg <= ACK_DONE;
            end
         end
         if (scl_fall) begin
            case (bit_cnt_reg)
               ACK_SLOT: begin
                  case (state_reg)
                     D_CTRL: begin
                        if (ctrl_match) begin
                           sda_oe_reg <= 1'b1;
                           rw_reg <= rx_reg[RW_BIT];
                           block_reg <= rx_reg[BLOCK_MSB:BLOCK_LSB];
                        end else begin
                           state_reg <= D_IDLE;
                        end
                     end
                     D_ADDR: sda_oe_reg <= 1'b1;
                     D_WDATA: sda_oe_reg <= 1'b1;
                     default: sda_oe_reg <= 1'b0;
                  endcase
               end
               ACK_DONE: begin
                  bit_cnt_reg <= 4'h0;
                  sda_oe_reg <= 1'b0;
                  case (state_reg)
                     D_CTRL: state_reg <= rw_reg ? D_READ : D_ADDR;
                     D_ADDR: state_reg <= D_WDATA;
                     D_READ: begin
                        if (!master_ack_reg) begin
                           state_reg <= D_IDLE;
                        end
                     end
                     default: state_reg <= state_reg;
                  endcase
                  if (read_load) begin
                     tx_reg <= rd_byte;
                     sda_oe_reg <= !rd_byte[7];
                  end
               end
               default: begin
                  if (state_reg == D_READ && bit_cnt_reg != 4'h0) begin
                     tx_reg <= {tx_reg[6:0], 1'b0};
                     sda_oe_reg <= !tx_reg[6];
                  end
               end
            endcase
         end
      end
   end

   // Address pointer: last accessed location plus one, wrapping over the whole array
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ptr_reg <= '0;
      end else if (addr_load) begin
         ptr_reg <= {block_reg, rx_reg};
      end else if (data_take || read_load) begin
         ptr_reg <= ptr_reg + 1'b1;
      end
   end

   // Pending write byte, dropped by a repeated Start, committed by Stop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_addr_reg <= '0;
         pend_data_reg <= 8'h00;
         pend_valid_reg <= 1'b0;
      end else if (data_take) begin
         pend_addr_reg <= ptr_reg;
         pend_data_reg <= rx_reg;
         pend_valid_reg <= 1'b1;
      end else if (start_cond || stop_cond) begin
         pend_valid_reg <= 1'b0;
      end
   end

   // Self-timed programming cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_reg <= 1'b0;
         busy_cnt_reg <= '0;
      end else if (stop_cond && pend_valid_reg) begin
         busy_reg <= 1'b1;
         busy_cnt_reg <= '0;
      end else if (prog_done) begin
         busy_reg <= 1'b0;
      end else if (busy_reg) begin
         busy_cnt_reg <= busy_cnt_reg + 1'b1;
      end
   end

   // Array write at the end of the programming cycle
   always_ff @(posedge clk) begin
      if (prog_done) begin
         mem[pend_addr_reg] <= pend_data_reg;
      end
   end

   assign bus.sda_s_o = 1'b0;
   assign bus.sda_s_oe = sda_oe_reg;
   assign write_busy = busy_reg;
endmodule : eeprom_device

/* File: design/eeprom_host.sv */
// Bus master end: SCL generation, Start/Stop, byte engine and command sequencing
`timescale 1ns/1ps
module eeprom_host #(
   parameter int QUARTER = eeprom_pkg::QUARTER_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   two_wire_if.master bus,
   input wire logic cmd_start,
   input wire eeprom_pkg::op_t cmd_op,
   input wire logic [eeprom_pkg::ADDR_W-1:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic [7:0] cmd_read_len,
   output logic cmd_busy,
   output logic cmd_done,
   output logic cmd_acked,
   output logic [7:0] rdata,
   output logic rdata_valid
);
   import eeprom_pkg::*;

   localparam int DIV_W = $clog2(QUARTER + 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(QUARTER - 1);

   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;

   host_state_t state_reg;
   logic [DIV_W-1:0] div_reg;
   logic tick_reg;
   logic [1:0] phase_reg;
   op_t op_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [7:0] wdata_reg;
   logic [7:0] remain_reg;
   logic [1:0] step_reg;
   logic rstart_reg;
   logic rd_reg;
   logic tx_mode_reg;
   logic [7:0] sh_reg;
   logic [3:0] bit_cnt_reg;
   logic scl_oe_reg;
   logic sda_oe_reg;
   logic done_reg;
   logic acked_reg;
   logic [7:0] rdata_reg;
   logic rvalid_reg;
   logic busy_reg;
   logic ctrl_rd;

   // Quarter-bit enable pulse from the system clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_reg <= '0;
         tick_reg <= 1'b0;
      end else if (state_reg == H_IDLE || div_reg == DIV_LAST) begin
         div_reg <= '0;
         tick_reg <= (state_reg != H_IDLE);
      end else begin
         div_reg <= div_reg + 1'b1;
         tick_reg <= 1'b0;
      end
   end

   assign ctrl_rd = (op_reg == OP_CURRENT_READ) || rstart_reg;

   // Command sequencer and bit engine
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= H_IDLE;
         phase_reg <= 2'h0;
         op_reg <= OP_WRITE;
         addr_reg <= '0;
         wdata_reg <= 8'h00;
         remain_reg <= LEN_DEFAULT;
         step_reg <= 2'h0;
         rstart_reg <= 1'b0;
         rd_reg <= 1'b0;
         tx_mode_reg <= 1'b1;
         sh_reg <= 8'h00;
         bit_cnt_reg <= 4'h0;
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         done_reg <= 1'b0;
         acked_reg <= 1'b0;
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         if (state_reg == H_IDLE) begin
            if (cmd_start) begin
               state_reg <= H_START;
               busy_reg <= 1'b1;
               phase_reg <= 2'h0;
               op_reg <= cmd_op;
               addr_reg <= cmd_addr;
               wdata_reg <= cmd_wdata;
               remain_reg <= (cmd_read_len == 8'h00) ? LEN_DEFAULT : cmd_read_len;
               rstart_reg <= 1'b0;
               acked_reg <= 1'b0;
            end
         end else if (tick_reg) begin
            phase_reg <= phase_reg + 2'h1;
            case (state_reg)
               H_START: begin
                  case (phase_reg)
                     2'h0: scl_oe_reg <= 1'b1;
                     2'h1: sda_oe_reg <= 1'b0;
                     2'h2: scl_oe_reg <= 1'b0;
                     default: begin
                        sda_oe_reg <= 1'b1;
                        state_reg <= H_BIT;
                        sh_reg <= {CTRL_CODE, 1'b0, addr_reg[ADDR_W-1:ADDR_W-2], ctrl_rd};
                        rd_reg <= ctrl_rd;
                        tx_mode_reg <= 1'b1;
                        step_reg <= 2'h0;
                        bit_cnt_reg <= 4'h0;
                     end
                  endcase
               end
               H_BIT: begin
                  case (phase_reg)
                     2'h0: scl_oe_reg <= 1'b1;
                     2'h1: begin
                        if (bit_cnt_reg < ACK_SLOT) begin
                           sda_oe_reg <= tx_mode_reg && !sh_reg[7];
                        end else begin
                           sda_oe_reg <= !tx_mode_reg && (remain_reg > 8'h01);
                        end
                     end
                     2'h2: scl_oe_reg <= 1'b0;
                     default: begin
                        if (bit_cnt_reg < ACK_SLOT) begin
                           sh_reg <= {sh_reg[6:0], tx_mode_reg ? 1'b0 : bus.sda};
                           bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else begin
                           bit_cnt_reg <= 4'h0;
                           if (!tx_mode_reg) begin
                              rdata_reg <= sh_reg;
                              rvalid_reg <= 1'b1;
                              remain_reg <= remain_reg - 8'h01;
                              if (remain_reg == 8'h01) begin
                                 state_reg <= H_STOP;
                                 acked_reg <= 1'b1;
                              end
                           end else if (bus.sda) begin
                              state_reg <= H_STOP;
                              acked_reg <= 1'b0;
                           end else begin
                              case (step_reg)
                                 2'h0: begin
                                    if (rd_reg) begin
                                       tx_mode_reg <= 1'b0;
                                    end else if (op_reg == OP_ACK_POLL) begin
                                       state_reg <= H_STOP;
                                       acked_reg <= 1'b1;
                                    end else begin
                                       sh_reg <= addr_reg[7:0];
                                       step_reg <= 2'h1;
                                    end
                                 end
                                 2'h1: begin
                                    if (op_reg == OP_WRITE) begin
                                       sh_reg <= wdata_reg;
                                       step_reg <= 2'h2;
                                    end else begin
                                       state_reg <= H_START;
                                       rstart_reg <= 1'b1;
                                    end
                                 end
                                 default: begin
                                    state_reg <= H_STOP;
                                    acked_reg <= 1'b1;
                                 end
                              endcase
                           end
                        end
                     end
                  endcase
               end
               H_STOP: begin
                  case (phase_reg)
                     2'h0: scl_oe_reg <= 1'b1;
                     2'h1: sda_oe_reg <= 1'b1;
                     2'h2: scl_oe_reg <= 1'b0;
                     default: begin
                        sda_oe_reg <= 1'b0;
                        state_reg <= H_IDLE;
                        busy_reg <= 1'b0;
                        done_reg <= 1'b1;
                     end
                  endcase
               end
               default: begin
                  state_reg <= H_IDLE;
                  busy_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   assign bus.scl_m_o = 1'b0;
   assign bus.scl_m_oe = scl_oe_reg;
   assign bus.sda_m_o = 1'b0;
   assign bus.sda_m_oe = sda_oe_reg;
   assign cmd_busy = busy_reg;
   assign cmd_done = done_reg;
   assign cmd_acked = acked_reg;
   assign rdata = rdata_reg;
   assign rdata_valid = rvalid_reg;
endmodule : eeprom_host

/* File: tb/eeprom_monitor.sv */
// Protocol checker watching the two-wire link between host and EEPROM device
`timescale 1ns/1ps
module eeprom_monitor #(
   parameter int FILTER_LEN = 4,
   parameter int WRITE_CYCLES_P = 1500
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_s_oe,
   input wire logic sda_m_oe,
   input wire logic write_busy
);
   logic scl_reg;
   logic sda_reg;
   logic start_ev;
   logic stop_ev;
   logic [3:0] bit_cnt_reg;
   logic [7:0] since_stop_reg;
   logic [31:0] busy_cnt_reg;

   default clocking mon_cb @(posedge clk);
   endclocking
   default disable iff (rst);

   assign start_ev = scl && scl_reg && !sda && sda_reg;
   assign stop_ev = scl && scl_reg && sda && !sda_reg;

   // Line levels one cycle back
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
      end else begin
         scl_reg <= scl;
         sda_reg <= sda;
      end
   end

   // Clock pulses since the last Start or Stop, saturating
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bit_cnt_reg <= 4'h0;
      end else if (start_ev || stop_ev) begin
         bit_cnt_reg <= 4'h0;
      end else if (scl && !scl_reg && bit_cnt_reg != 4'hf) begin
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
   end

   // Cycles since the last Stop and length of the programming cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         since_stop_reg <= 8'hff;
         busy_cnt_reg <= 32'h0;
      end else begin
         since_stop_reg <= stop_ev ? 8'h00 : (since_stop_reg == 8'hff ? 8'hff : since_stop_reg + 8'h01);
         busy_cnt_reg <= write_busy ? busy_cnt_reg + 32'h1 : 32'h0;
      end
   end

   busy_no_ack_a: assert property (write_busy |-> !sda_s_oe)
      else $error("device drives data line while programming");
   stop_prog_a: assert property ($rose(write_busy) |-> since_stop_reg <= FILTER_LEN + 6)
      else $error("programming began without a recent Stop");
   busy_hold_a: assert property ($rose(write_busy) |=> write_busy [*8])
      else $error("programming cycle dropped at once");
   busy_len_a: assert property ($fell(write_busy) |->
      busy_cnt_reg >= WRITE_CYCLES_P - 2 && busy_cnt_reg <= WRITE_CYCLES_P + 2)
      else $error("programming cycle length off");
   ack_low_a: assert property ($rose(sda_s_oe) |-> !scl)
      else $error("device changed data line while clock high");
   ctrl_ack_a: assert property ($rose(sda_s_oe) && bit_cnt_reg <= 4'h9 |-> bit_cnt_reg == 4'h8)
      else $error("control byte acknowledged at wrong bit");
   ctrl_quiet_a: assert property (bit_cnt_reg >= 4'h1 && bit_cnt_reg <= 4'h7 |-> !sda_s_oe)
      else $error("device drives during control byte");
   start_release_a: assert property (start_ev |-> ##[0:8] !sda_s_oe)
      else $error("device holds data line after Start");
   stop_quiet_a: assert property (stop_ev |=> !sda_s_oe [*8])
      else $error("device drives data line after Stop");
   host_sda_stable_a: assert property ($changed(sda_m_oe) && scl |-> start_ev || stop_ev)
      else $error("host changed data line while clock high");

   cover property ($fell(write_busy));
endmodule : eeprom_monitor

/* File: tb/tb.sv */
// Self-checking bench: host and EEPROM device joined over the two-wire link
`timescale 1ns/1ps
module tb;
   import eeprom_pkg::*;
   localparam int QUARTER_TB = 12;
   localparam int WRITE_TB = 1500;
   localparam int FILTER_TB = 4;
   logic clk;
   logic rst;
   logic cmd_start;
   op_t cmd_op;
   logic [ADDR_W-1:0] cmd_addr;
   logic [7:0] cmd_wdata;
   logic [7:0] cmd_read_len;
   logic cmd_busy;
   logic cmd_done;
   logic cmd_acked;
   logic [7:0] rdata;
   logic rdata_valid;
   logic write_busy;
   logic busy_seen;
   logic [7:0] got_q[$];
   int error_cnt;
   int checks_done;

   two_wire_if bus_if ();
   eeprom_host #(.QUARTER(QUARTER_TB)) eeprom_host_inst (.clk(clk), .rst(rst), .bus(bus_if.master),
      .cmd_start(cmd_start), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_read_len(cmd_read_len), .cmd_busy(cmd_busy), .cmd_done(cmd_done), .cmd_acked(cmd_acked),
      .rdata(rdata), .rdata_valid(rdata_valid));
   eeprom_device #(.WRITE_CYCLES_P(WRITE_TB), .FILTER_LEN(FILTER_TB), .ADDR_W(ADDR_W)) eeprom_device_inst (
      .clk(clk), .rst(rst), .bus(bus_if.device), .write_busy(write_busy));
   eeprom_monitor #(.FILTER_LEN(FILTER_TB), .WRITE_CYCLES_P(WRITE_TB)) eeprom_monitor_inst (.clk(clk),
      .rst(rst), .scl(bus_if.scl), .sda(bus_if.sda), .sda_s_oe(bus_if.sda_s_oe), .sda_m_oe(bus_if.sda_m_oe),
      .write_busy(write_busy));

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report

   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check8

   task automatic check1(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check1

   // One host command, collecting received bytes until done
   task automatic run_cmd(input op_t op, input logic [9:0] addr, input logic [7:0] wdata, input logic [7:0] len);
      int n;
      got_q.delete();
      busy_seen = 1'b0;
      while (cmd_busy !== 1'b0) @(negedge clk);
      @(posedge clk);
      cmd_op <= op;
      cmd_addr <= addr;
      cmd_wdata <= wdata;
      cmd_read_len <= len;
      cmd_start <= 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (cmd_busy !== 1'b1 && n < 100);
      @(posedge clk);
      cmd_start <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         if (rdata_valid === 1'b1) got_q.push_back(rdata);
         if (write_busy === 1'b1) busy_seen = 1'b1;
         n++;
      end while (cmd_done !== 1'b1 && n < 20000);
      check1(cmd_done, 1'b1);
   endtask : run_cmd

   // Write one byte, then poll until the programming cycle ends
   task automatic test_write(input logic [9:0] addr, input logic [7:0] data);
      int n;
      run_cmd(OP_WRITE, addr, data, 8'h01);
      check1(cmd_acked, 1'b1);
      n = 0;
      while (write_busy !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      check1(write_busy, 1'b1);
      run_cmd(OP_ACK_POLL, addr, 8'h00, 8'h01);
      check1(cmd_acked, 1'b0);
      n = 0;
      while (cmd_acked !== 1'b1 && n < 10) begin
         run_cmd(OP_ACK_POLL, addr, 8'h00, 8'h01);
         n++;
      end
      check1(cmd_acked, 1'b1);
      check1(write_busy, 1'b0);
      $display("write test at %h finished", addr);
   endtask : test_write

   task automatic test_reads();
      run_cmd(OP_CURRENT_READ, 10'h000, 8'h00, 8'h01);
      check8(got_q[0], 8'h3c);
      run_cmd(OP_RANDOM_READ, 10'h3ff, 8'h00, 8'h01);
      check1(cmd_acked, 1'b1);
      check8(8'(got_q.size()), 8'h01);
      check8(got_q[0], 8'ha5);
      check1(busy_seen, 1'b0);
      check1(bus_if.sda, 1'b1);
      run_cmd(OP_CURRENT_READ, 10'h155, 8'h00, 8'h01);
      check8(got_q[0], 8'h3c);
      run_cmd(OP_RANDOM_READ, 10'h3ff, 8'h00, 8'h02);
      check8(8'(got_q.size()), 8'h02);
      check8(got_q[0], 8'ha5);
      check8(got_q[1], 8'h3c);
      run_cmd(OP_CURRENT_READ, 10'h000, 8'h00, 8'h01);
      check8(got_q[0], 8'h96);
      $display("read tests finished");
   endtask : test_reads

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      rst = 1'b1;
      cmd_start = 1'b0;
      cmd_op = OP_WRITE;
      cmd_addr = 10'h000;
      cmd_wdata = 8'h00;
      cmd_read_len = 8'h01;
      error_cnt = 0;
      checks_done = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      test_write(10'h001, 8'h96);
      test_write(10'h000, 8'h3c);
      test_write(10'h3ff, 8'ha5);
      test_reads();
      final_report();
   end

   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      $display("watchdog expired at %0t", $time);
      final_report();
   end
endmodule : tb
